// ---- freq_gen_pkg.sv ----
// Shared constants for the square-wave generator and its port
package freq_gen_pkg;

    // ------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_RELOAD = 16'h1fb8;
    localparam logic [15:0] ADDR_COUNT = 16'h1fba;
    localparam logic [15:0] ADDR_MODE = 16'h1fd1;
    localparam logic [15:0] ADDR_DIR = 16'h1fd3;
    localparam logic [15:0] ADDR_LATCH = 16'h1fd5;
    localparam logic [15:0] ADDR_PIN = 16'h1fd7;

    // ------------------------------------------------------------
    // Reset values and unmapped read answer
    // ------------------------------------------------------------
    localparam logic [7:0] RELOAD_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic [7:0] LATCH_RESET = 8'h00;
    localparam logic [7:0] RDATA_IDLE = 8'h00;
    localparam logic [7:0] COUNT_ZERO = 8'h00;
    localparam logic [7:0] COUNT_ONE = 8'h01;

    // ------------------------------------------------------------
    // Step timing: one decrement every eighth state time
    // ------------------------------------------------------------
    localparam int STATE_TIMES_PER_STEP = 8;
    localparam int PRESCALE_W = $clog2(STATE_TIMES_PER_STEP);
    localparam logic [PRESCALE_W-1:0] PRESCALE_ZERO = '0;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST =
        PRESCALE_W'(STATE_TIMES_PER_STEP - 1);

    // ------------------------------------------------------------
    // Port bit positions of the special functions
    // ------------------------------------------------------------
    localparam int BIT_CC4 = 0;
    localparam int BIT_CC5 = 1;
    localparam int BIT_CMP4 = 2;
    localparam int BIT_CMP5 = 3;
    localparam int BIT_WAVE = 7;

    // Source that drives a port bit
    typedef enum logic [2:0] {
        SRC_LATCH = 3'h0,
        SRC_CC4 = 3'h1,
        SRC_CC5 = 3'h3,
        SRC_CMP4 = 3'h2,
        SRC_CMP5 = 3'h6,
        SRC_WAVE = 3'h7
    } pin_source_type;

endpackage : freq_gen_pkg

// ---- freq_gen_if.sv ----
// Carrier between the register block and the generator core
`timescale 1ns/1ns
`default_nettype none

interface freq_gen_if;
    logic [7:0] reload_value;
    logic [7:0] period_count;
    logic wave_level;
    logic step_tick;

    modport core (
        input reload_value,
        output period_count,
        output wave_level,
        output step_tick
    );

    modport regs (
        output reload_value,
        input period_count,
        input wave_level,
        input step_tick
    );
endinterface : freq_gen_if

`default_nettype wire

// ---- freq_gen_core.sv ----
// Period down-counter, step prescaler and output toggle of the generator
`timescale 1ns/1ns
`default_nettype none

module freq_gen_core (
    input wire logic clk,
    input wire logic rst_n,
    freq_gen_if.core fg
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [freq_gen_pkg::PRESCALE_W-1:0] prescale_reg;
    logic [freq_gen_pkg::PRESCALE_W-1:0] prescale_next;
    logic [7:0] count_reg;
    logic [7:0] count_next;
    logic wave_reg;
    logic wave_next;
    logic tick;

    // Step tick once every eighth state time
    assign tick = (prescale_reg == freq_gen_pkg::PRESCALE_LAST);

    // Next values: hold, decrement, or toggle and reload at zero
    always_comb begin
        prescale_next = prescale_reg + 1'b1;
        count_next = count_reg;
        wave_next = wave_reg;
        if (tick) begin
            if (count_reg == freq_gen_pkg::COUNT_ZERO) begin
                count_next = fg.reload_value;
                wave_next = ~wave_reg;
            end else begin
                count_next = count_reg - freq_gen_pkg::COUNT_ONE;
            end
        end
    end

    // Registers; counter starts from the reload reset value
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prescale_reg <= freq_gen_pkg::PRESCALE_ZERO;
            count_reg <= freq_gen_pkg::RELOAD_RESET;
            wave_reg <= 1'b0;
        end else begin
            prescale_reg <= prescale_next;
            count_reg <= count_next;
            wave_reg <= wave_next;
        end
    end

    assign fg.period_count = count_reg;
    assign fg.wave_level = wave_reg;
    assign fg.step_tick = tick;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_step_spacing;
        tick |=> !tick [*7] ##1 tick;
    endproperty
    a_step_spacing: assert property (p_step_spacing)
        else $error("step tick not every eighth state time");

    property p_decrement;
        tick && count_reg != freq_gen_pkg::COUNT_ZERO |=>
            count_reg == $past(count_reg) - freq_gen_pkg::COUNT_ONE && $stable(wave_reg);
    endproperty
    a_decrement: assert property (p_decrement)
        else $error("counter did not decrement by one on step");

    property p_hold;
        !tick |=> $stable(count_reg) && $stable(wave_reg);
    endproperty
    a_hold: assert property (p_hold)
        else $error("counter moved between steps");

    property p_zero_reload;
        tick && count_reg == freq_gen_pkg::COUNT_ZERO |=>
            count_reg == $past(fg.reload_value) && wave_reg != $past(wave_reg);
    endproperty
    a_zero_reload: assert property (p_zero_reload)
        else $error("zero did not toggle and reload");

    // Zero reload held steady: the toggle after the next step shows one edge later
    property p_equal_halves;
        tick && count_reg == freq_gen_pkg::COUNT_ZERO
            && fg.reload_value == freq_gen_pkg::COUNT_ZERO
            ##1 $stable(fg.reload_value) [*8] |=> $changed(wave_reg);
    endproperty
    a_equal_halves: assert property (p_equal_halves)
        else $error("half period with zero reload is not eight state times");

    property p_reset_start;
        $rose(rst_n) |-> wave_reg == 1'b0;
    endproperty
    a_reset_start: assert property (p_reset_start)
        else $error("output not low after reset");

    c_toggle: cover property ($changed(wave_reg));

endmodule : freq_gen_core

`default_nettype wire

// ---- square_wave_frequency_generator.sv ----
// Top of the square-wave generator with its register port and port 7 pins
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module square_wave_frequency_generator (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [15:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] port7_in,
    output logic [7:0] port7_out,
    output logic [7:0] port7_oe,
    input wire logic capture_compare_ch4_out,
    input wire logic capture_compare_ch4_oe,
    input wire logic capture_compare_ch5_out,
    input wire logic capture_compare_ch5_oe,
    input wire logic compare_only_ch4_out,
    input wire logic compare_only_ch5_out,
    output logic [1:0] capture_compare_in
);

    // ------------------------------------------------------------
    // Reset release through two flip-flops
    // ------------------------------------------------------------
    logic rst_meta_reg;
    logic rst_n;

    // Assert at once, release only after two clean edges
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Generator core
    // ------------------------------------------------------------
    freq_gen_if fg ();

    freq_gen_core u_core (
        .clk(clk),
        .rst_n(rst_n),
        .fg(fg.core)
    );

    // ------------------------------------------------------------
    // Pin level synchroniser
    // ------------------------------------------------------------
    logic [7:0] pin_meta_reg;
    logic [7:0] pin_sync_reg;

    // Pins are asynchronous; only the second stage is ever read
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta_reg <= 8'h00;
            pin_sync_reg <= 8'h00;
        end else begin
            pin_meta_reg <= port7_in;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] reload_reg;
    logic [7:0] reload_next;
    logic [7:0] mode_reg;
    logic [7:0] mode_next;
    logic [7:0] dir_reg;
    logic [7:0] dir_next;
    logic [7:0] latch_reg;
    logic [7:0] latch_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;

    // Write decode; counter address falls through and changes nothing
    always_comb begin
        reload_next = reload_reg;
        mode_next = mode_reg;
        dir_next = dir_reg;
        latch_next = latch_reg;
        if (reg_wr) begin
            if (reg_addr == freq_gen_pkg::ADDR_RELOAD) begin
                reload_next = reg_wdata;
            end else if (reg_addr == freq_gen_pkg::ADDR_MODE) begin
                mode_next = reg_wdata;
            end else if (reg_addr == freq_gen_pkg::ADDR_DIR) begin
                dir_next = reg_wdata;
            end else if (reg_addr == freq_gen_pkg::ADDR_LATCH) begin
                latch_next = reg_wdata;
            end
        end
    end

    // Read decode; data stands only in the cycle after the strobe
    always_comb begin
        rdata_next = freq_gen_pkg::RDATA_IDLE;
        if (reg_rd) begin
            if (reg_addr == freq_gen_pkg::ADDR_RELOAD) begin
                rdata_next = reload_reg;
            end else if (reg_addr == freq_gen_pkg::ADDR_COUNT) begin
                rdata_next = fg.period_count;
            end else if (reg_addr == freq_gen_pkg::ADDR_MODE) begin
                rdata_next = mode_reg;
            end else if (reg_addr == freq_gen_pkg::ADDR_DIR) begin
                rdata_next = dir_reg;
            end else if (reg_addr == freq_gen_pkg::ADDR_LATCH) begin
                rdata_next = latch_reg;
            end else if (reg_addr == freq_gen_pkg::ADDR_PIN) begin
                rdata_next = pin_sync_reg;
            end
        end
    end

    // Register storage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reload_reg <= freq_gen_pkg::RELOAD_RESET;
            mode_reg <= freq_gen_pkg::MODE_RESET;
            dir_reg <= freq_gen_pkg::DIR_RESET;
            latch_reg <= freq_gen_pkg::LATCH_RESET;
            rdata_reg <= freq_gen_pkg::RDATA_IDLE;
        end else begin
            reload_reg <= reload_next;
            mode_reg <= mode_next;
            dir_reg <= dir_next;
            latch_reg <= latch_next;
            rdata_reg <= rdata_next;
        end
    end

    assign fg.reload_value = reload_reg;
    assign reg_rdata = rdata_reg;

    // ------------------------------------------------------------
    // Port 7 pin routing
    // ------------------------------------------------------------
    logic [7:0] pin_out_next;
    logic [7:0] pin_oe_next;
    logic [7:0] pin_out_reg;
    logic [7:0] pin_oe_reg;
    freq_gen_pkg::pin_source_type pin_src [8];

    // Bits 0..3 and 7: their special source when selected, else the latch
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_pin
            always_comb begin
                pin_src[k] = freq_gen_pkg::SRC_LATCH;
                if (mode_reg[k]) begin
                    if (k == freq_gen_pkg::BIT_CC4) begin
                        pin_src[k] = freq_gen_pkg::SRC_CC4;
                    end else if (k == freq_gen_pkg::BIT_CC5) begin
                        pin_src[k] = freq_gen_pkg::SRC_CC5;
                    end else if (k == freq_gen_pkg::BIT_CMP4) begin
                        pin_src[k] = freq_gen_pkg::SRC_CMP4;
                    end else if (k == freq_gen_pkg::BIT_CMP5) begin
                        pin_src[k] = freq_gen_pkg::SRC_CMP5;
                    end else if (k == freq_gen_pkg::BIT_WAVE) begin
                        pin_src[k] = freq_gen_pkg::SRC_WAVE;
                    end
                end
            end

            // Compare outputs always drive; capture channels own their enable
            always_comb begin
                case (pin_src[k])
                    freq_gen_pkg::SRC_CC4: begin
                        pin_out_next[k] = capture_compare_ch4_out;
                        pin_oe_next[k] = capture_compare_ch4_oe;
                    end
                    freq_gen_pkg::SRC_CC5: begin
                        pin_out_next[k] = capture_compare_ch5_out;
                        pin_oe_next[k] = capture_compare_ch5_oe;
                    end
                    freq_gen_pkg::SRC_CMP4: begin
                        pin_out_next[k] = compare_only_ch4_out;
                        pin_oe_next[k] = 1'b1;
                    end
                    freq_gen_pkg::SRC_CMP5: begin
                        pin_out_next[k] = compare_only_ch5_out;
                        pin_oe_next[k] = 1'b1;
                    end
                    freq_gen_pkg::SRC_WAVE: begin
                        pin_out_next[k] = fg.wave_level;
                        pin_oe_next[k] = 1'b1;
                    end
                    default: begin
                        pin_out_next[k] = latch_reg[k];
                        pin_oe_next[k] = dir_reg[k];
                    end
                endcase
            end
        end
    endgenerate

    // Pin drivers registered so outputs leave straight from flops
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pin_out_reg <= 8'h00;
            pin_oe_reg <= 8'h00;
        end else begin
            pin_out_reg <= pin_out_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    assign port7_out = pin_out_reg;
    assign port7_oe = pin_oe_reg;
    // Capture inputs see the synchronised pin, whatever drives it
    assign capture_compare_in = {pin_sync_reg[freq_gen_pkg::BIT_CC5],
                                 pin_sync_reg[freq_gen_pkg::BIT_CC4]};

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_reload_write;
        reg_wr && reg_addr == freq_gen_pkg::ADDR_RELOAD |=> reload_reg == $past(reg_wdata);
    endproperty
    a_reload_write: assert property (p_reload_write)
        else $error("reload value not stored");

    property p_reload_read;
        reg_rd && reg_addr == freq_gen_pkg::ADDR_RELOAD |=> reg_rdata == $past(reload_reg);
    endproperty
    a_reload_read: assert property (p_reload_read)
        else $error("reload value not read back");

    property p_dir_write;
        reg_wr && reg_addr == freq_gen_pkg::ADDR_DIR |=> dir_reg == $past(reg_wdata);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction register not written");

    property p_latch_write;
        reg_wr && reg_addr == freq_gen_pkg::ADDR_LATCH |=> latch_reg == $past(reg_wdata);
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("output latch not written");

    // Stale read data would be mistaken for a fresh answer
    property p_rdata_idle;
        !reg_rd |=> reg_rdata == freq_gen_pkg::RDATA_IDLE;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data stood longer than one cycle");

    property p_capture5_route;
        mode_reg[freq_gen_pkg::BIT_CC5] |=>
            port7_out[freq_gen_pkg::BIT_CC5] == $past(capture_compare_ch5_out)
            && port7_oe[freq_gen_pkg::BIT_CC5] == $past(capture_compare_ch5_oe);
    endproperty
    a_capture5_route: assert property (p_capture5_route)
        else $error("channel 5 capture/compare not routed");

    property p_compare_only_ch4_route;
        mode_reg[freq_gen_pkg::BIT_CMP4] |=>
            port7_out[freq_gen_pkg::BIT_CMP4] == $past(compare_only_ch4_out)
            && port7_oe[freq_gen_pkg::BIT_CMP4];
    endproperty
    a_compare_only_ch4_route: assert property (p_compare_only_ch4_route)
        else $error("compare-only channel 4 not routed");

    property p_count_read;
        reg_rd && reg_addr == freq_gen_pkg::ADDR_COUNT |=>
            reg_rdata == $past(fg.period_count);
    endproperty
    a_count_read: assert property (p_count_read)
        else $error("counter read returned wrong value");

    property p_count_read_only;
        reg_wr && reg_addr == freq_gen_pkg::ADDR_COUNT && !fg.step_tick |=>
            $stable(fg.period_count) && $stable(reload_reg);
    endproperty
    a_count_read_only: assert property (p_count_read_only)
        else $error("write to counter changed state");

    property p_wave_on_pin;
        mode_reg[freq_gen_pkg::BIT_WAVE] |=>
            port7_out[freq_gen_pkg::BIT_WAVE] == $past(fg.wave_level)
            && port7_oe[freq_gen_pkg::BIT_WAVE];
    endproperty
    a_wave_on_pin: assert property (p_wave_on_pin)
        else $error("square wave not on bit 7");

    property p_plain_io;
        !mode_reg[freq_gen_pkg::BIT_WAVE] |=>
            port7_out[freq_gen_pkg::BIT_WAVE] == $past(latch_reg[freq_gen_pkg::BIT_WAVE])
            && port7_oe[freq_gen_pkg::BIT_WAVE] == $past(dir_reg[freq_gen_pkg::BIT_WAVE]);
    endproperty
    a_plain_io: assert property (p_plain_io)
        else $error("bit 7 not plain I/O when unselected");

    property p_capture_route;
        mode_reg[freq_gen_pkg::BIT_CC4] |=>
            port7_out[freq_gen_pkg::BIT_CC4] == $past(capture_compare_ch4_out)
            && port7_oe[freq_gen_pkg::BIT_CC4] == $past(capture_compare_ch4_oe);
    endproperty
    a_capture_route: assert property (p_capture_route)
        else $error("channel 4 capture/compare not routed");

    property p_compare_route;
        mode_reg[freq_gen_pkg::BIT_CMP5] |=>
            port7_out[freq_gen_pkg::BIT_CMP5] == $past(compare_only_ch5_out)
            && port7_oe[freq_gen_pkg::BIT_CMP5];
    endproperty
    a_compare_route: assert property (p_compare_route)
        else $error("compare-only channel 5 not routed");

    property p_mode_write;
        reg_wr && reg_addr == freq_gen_pkg::ADDR_MODE |=> mode_reg == $past(reg_wdata);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode register not written");

    property p_pin_read;
        reg_rd && reg_addr == freq_gen_pkg::ADDR_PIN |=> reg_rdata == $past(pin_sync_reg);
    endproperty
    a_pin_read: assert property (p_pin_read)
        else $error("pin level read wrong");

    c_wave_pin: cover property (mode_reg[freq_gen_pkg::BIT_WAVE] ##1 $changed(port7_out[7]));
    c_count_write: cover property (reg_wr && reg_addr == freq_gen_pkg::ADDR_COUNT);
    c_reload_zero: cover property (fg.step_tick && fg.period_count == freq_gen_pkg::COUNT_ZERO);
    c_compare_pin: cover property (mode_reg[freq_gen_pkg::BIT_CMP4]);

endmodule : square_wave_frequency_generator

`default_nettype wire

// ---- freq_gen_pin_model.sv ----
// Outside circuit on the port 7 pins, resolving each pin's level
`timescale 1ns/1ns
`default_nettype none

module freq_gen_pin_model (
    input wire logic [7:0] port7_out,
    input wire logic [7:0] port7_oe,
    input wire logic [7:0] ext_level,
    output logic [7:0] pin_level
);
    // ------------------------------------------------------------
    // Pin resolution
    // ------------------------------------------------------------
    // Device wins where enabled; elsewhere the outside load sets the level
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            pin_level[i] = port7_oe[i] ? port7_out[i] : ext_level[i];
        end
    end
endmodule : freq_gen_pin_model

`default_nettype wire

// ---- tb_square_wave_frequency_generator.sv ----
// Self-checking bench for the square-wave generator and port 7
`timescale 1ns/1ns
`default_nettype none

module tb_square_wave_frequency_generator;
    localparam int FXTAL = 16000000; // Crystal assumed for reload math
    localparam int WAIT_LIMIT = 4096; // Longest half period is 256 steps of 8
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, port7_out, port7_oe, port7_in;
    logic [7:0] ext_level = 8'h00;
    logic [5:0] chan = 6'h00; // cmp5, cmp4, cc5 oe/out, cc4 oe/out
    logic [1:0] capture_compare_in;
    logic [7:0] exp_q[$];
    logic rd_q = 1'b0;
    logic [15:0] amap [6] = '{freq_gen_pkg::ADDR_RELOAD, freq_gen_pkg::ADDR_COUNT,
        freq_gen_pkg::ADDR_MODE, freq_gen_pkg::ADDR_DIR, freq_gen_pkg::ADDR_LATCH,
        freq_gen_pkg::ADDR_PIN};
    int err_count = 0;
    int comparisons = 0;

    // ------------------------------------------------------------
    // Clock, device and outside circuit
    // ------------------------------------------------------------
    always #2 clk = ~clk;

    square_wave_frequency_generator uut (
        .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port7_in(port7_in),
        .port7_out(port7_out), .port7_oe(port7_oe),
        .capture_compare_ch4_out(chan[0]), .capture_compare_ch4_oe(chan[1]),
        .capture_compare_ch5_out(chan[2]), .capture_compare_ch5_oe(chan[3]),
        .compare_only_ch4_out(chan[4]), .compare_only_ch5_out(chan[5]),
        .capture_compare_in(capture_compare_in)
    );

    freq_gen_pin_model pins (
        .port7_out(port7_out), .port7_oe(port7_oe), .ext_level(ext_level),
        .pin_level(port7_in)
    );

    // ------------------------------------------------------------
    // Checking helpers
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic final_report();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : final_report

    // Read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_q) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("ERROR reg_rdata expected none seen %h", reg_rdata);
            end else begin
                check("reg_rdata", reg_rdata, exp_q.pop_front());
            end
        end
        rd_q <= reg_rd;
    end

    // ------------------------------------------------------------
    // Bus cycles and wave timing
    // ------------------------------------------------------------
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : rd

    // Bounded wait for the next wave edge; a hang ends the run
    task automatic half_period(output int n);
        logic last;
        last = port7_out[7];
        n = 0;
        while (port7_out[7] === last && n < WAIT_LIMIT) begin
            @(posedge clk);
            n++;
        end
        if (n >= WAIT_LIMIT) begin
            err_count++;
            $display("ERROR wave_edge expected toggle seen none");
            final_report();
        end
    endtask : half_period

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        int r;
        int n1;
        int n2;
        logic [7:0] v;
        r = $urandom(32'h4c51);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        repeat (4) @(posedge clk);
        // Reset contents, counter stuck at zero while reload is zero
        for (int i = 0; i < 6; i++) rd(amap[i], 8'h00);
        wr(amap[1], 8'hff);
        rd(amap[1], 8'h00);
        rd(16'h1fb9, freq_gen_pkg::RDATA_IDLE);
        // Read-write registers keep what was written
        foreach (amap[i]) if (i != 1 && i != 5) begin
            v = 8'($urandom);
            wr(amap[i], v);
            rd(amap[i], v);
        end
        // Plain output: latch drives every pin
        wr(amap[2], 8'h00);
        v = 8'($urandom);
        wr(amap[4], v);
        wr(amap[3], 8'hff);
        repeat (2) @(posedge clk);
        check("port7_out", port7_out, v);
        check("port7_oe", port7_oe, 8'hff);
        repeat (3) @(posedge clk);
        rd(amap[5], v);
        // Plain input: outside levels reach the pin register
        wr(amap[3], 8'h00);
        ext_level <= 8'($urandom);
        repeat (5) @(posedge clk);
        rd(amap[5], ext_level);
        check("capture_compare_in", {6'h00, capture_compare_in}, {6'h00, ext_level[1:0]});
        // Channel functions on the low nibble; bits 4..6 stay plain
        wr(amap[2], 8'h7f);
        for (int k = 0; k < 6; k++) begin
            chan <= 6'($urandom);
            repeat (3) @(posedge clk);
            check("port7_out", {4'h0, port7_out[3:0]}, {4'h0, chan[5], chan[4], chan[2], chan[0]});
            check("port7_oe", port7_oe, {6'h03, chan[3], chan[1]});
        end
        // Wave on bit 7, three reloads from crystal and wanted frequency, then one random reload of 0..7
        wr(amap[2], 8'h80);
        for (int k = 0; k < 4; k++) begin
            r = (k < 3) ? FXTAL / (16 * (1000000 >> k)) - 1 : $urandom_range(0, 7);
            wr(amap[0], 8'(r));
            half_period(n1);
            half_period(n1);
            half_period(n1);
            half_period(n2);
            check("wave_high_low", 8'(n1), 8'((r + 1) * 8));
            check("wave_high_low", 8'(n2), 8'((r + 1) * 8));
            check("port7_oe_bit7", {7'h00, port7_oe[7]}, 8'h01);
        end
        final_report();
    end
endmodule : tb_square_wave_frequency_generator

`default_nettype wire
